//--- branch_ctr_pkg.sv
// Purpose: Shared constants and types for the branch-to-count-register unit
// Assumes: 32-bit APB register access, big-endian bit numbering of the instruction word
// Notes:   Bit k of the instruction word sits at vector index 31-k

`default_nettype none

package branch_count_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_INSN     = 8'h00;
   localparam logic [7:0] OFS_CIA      = 8'h04;
   localparam logic [7:0] OFS_COUNT    = 8'h08;
   localparam logic [7:0] OFS_LINK     = 8'h0C;
   localparam logic [7:0] OFS_COND     = 8'h10;
   localparam logic [7:0] OFS_FXEXC    = 8'h14;
   localparam logic [7:0] OFS_CTRL     = 8'h18;
   localparam logic [7:0] OFS_GO       = 8'h1C;
   localparam logic [7:0] OFS_STATUS   = 8'h20;
   localparam logic [7:0] OFS_NEXT_PC  = 8'h24;

   // Control register field positions
   localparam int CTRL_NEW_ENC = 0;
   localparam int CTRL_LEGACY  = 1;

   // Instruction field positions (vector indices)
   localparam int OPTION_HI  = 25;
   localparam int OPTION_LO  = 21;
   localparam int SEL_HI     = 20;
   localparam int SEL_LO     = 16;
   localparam int HINT_HI    = 12;
   localparam int HINT_LO    = 11;
   localparam int PRIMARY_HI = 31;
   localparam int PRIMARY_LO = 26;
   localparam int EXT_HI     = 10;
   localparam int EXT_LO     = 1;
   localparam int LINK_POS   = 0;

   // Opcode values of this instruction
   localparam logic [5:0] PRIMARY_OP = 6'h13;
   localparam logic [9:0] EXT_OP     = 10'h210;

   // Reset values and arithmetic constants
   localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
   localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
   localparam logic [31:0] ONE        = 32'h0000_0001;
   localparam logic [1:0]  ALIGN_ZERO = 2'h0;
   localparam logic [4:0]  CR_TOP     = 5'h1F;

   // Prediction hint, in encoding order 00..11
   typedef enum logic [1:0] {PRED_NONE, PRED_RESERVED, PRED_NOT_TAKEN, PRED_TAKEN} pred_hint_t;

   // Branch hint field, in encoding order 00..11
   typedef enum logic [1:0] {TGT_SAME, TGT_RESERVED_1, TGT_RESERVED_2, TGT_UNPREDICTABLE} target_hint_t;

   // Outcome of the last executed branch
   typedef struct packed {
      logic         done;
      target_hint_t target_hint;
      pred_hint_t   pred_hint;
      logic         y_hint;
      logic         wrong_opcode;
      logic         invalid_form;
      logic         taken;
   } branch_status_t;

   // Decoded instruction fields
   typedef struct packed {
      logic [4:0] branch_option_field;
      logic [4:0] condition_bit_selector;
      logic [1:0] branch_hint_field;
      logic       link_bit;
   } branch_fields_t;

endpackage

`default_nettype wire

//--- branch_cond_to_count_reg.sv
// Purpose: Executes the conditional branch-to-count-register instruction, one per GO write
// Assumes: Software loads instruction, address, count, link and condition words over APB first
// Notes:   Zero wait states; read data is captured in the setup cycle
// Behaviour
// RL1: Target is count bits 0-29 plus 00
// RL2: Link bit set writes next address
// RL3: Exception register and field zero untouched
// RL4: Old decrement codes test count and condition
// RL5: Old 001zy/011zy test condition only
// RL6: Old 1z00y/1z01y test decremented count only
// RL7: Code 1z1zz branches always, no decrement
// RL8: Nonzero z bit marks invalid form
// RL9: Old y bit is only a hint
// RL10: Legacy variant accepts any z, y
// RL11: New decrement codes test count and condition
// RL12: New 001at/011at test condition, hint low
// RL13: New 1a00t/1a01t test decremented count only
// RL14: Two hint bits decode none/reserved/unlikely/likely
// RL15: Branch hint field decoded, two reserved
// RL16: Selector picks the tested condition bit
// RL17: Hints never change outcome or target
// RL18: Not taken goes to next sequential address

`default_nettype none

module branch_cond_to_count_reg
   import branch_count_pkg::*;
(
   // Clock and reset
   input  wire  logic        clk,
   input  wire  logic        resetn,
   // APB slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr
);
   import branch_count_pkg::*;

   // Architectural state held for software
   logic [31:0]    insn_reg;
   logic [31:0]    cia_reg;
   logic [31:0]    count_register_reg;
   logic [31:0]    link_reg;
   logic [31:0]    cond_reg;
   logic [31:0]    fxexc_reg;
   logic [1:0]     ctrl_reg;
   branch_status_t status_reg;
   logic [31:0]    next_pc_reg;
   logic [31:0]    prdata_reg;

   // Bus decode
   logic        setup_w;
   logic        access_w;
   logic        wr_w;
   logic        hit_w;
   logic [31:0] rd_mux_w;
   logic        exec_w;

   assign setup_w  = psel && !penable;
   assign access_w = psel && penable;
   assign wr_w     = access_w && pwrite;
   assign hit_w    = (paddr == OFS_INSN) || (paddr == OFS_CIA) || (paddr == OFS_COUNT) ||
                     (paddr == OFS_LINK) || (paddr == OFS_COND) || (paddr == OFS_FXEXC) ||
                     (paddr == OFS_CTRL) || (paddr == OFS_GO) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_NEXT_PC);
   assign exec_w   = wr_w && (paddr == OFS_GO);

   // Never stalls; unmapped offsets answer with an error and have no effect
   assign pready  = 1'b1;
   assign pslverr = access_w && !hit_w;
   assign prdata  = prdata_reg;

   // Field extraction
   branch_fields_t f_w;
   logic           b0, b1, b2, b3, b4;

   assign f_w = '{branch_option_field:    insn_reg[OPTION_HI:OPTION_LO],
                  condition_bit_selector: insn_reg[SEL_HI:SEL_LO],
                  branch_hint_field:      insn_reg[HINT_HI:HINT_LO],
                  link_bit:               insn_reg[LINK_POS]};
   // Option bit k maps to vector index 4-k
   assign b0 = f_w.branch_option_field[4];
   assign b1 = f_w.branch_option_field[3];
   assign b2 = f_w.branch_option_field[2];
   assign b3 = f_w.branch_option_field[1];
   assign b4 = f_w.branch_option_field[0];

   // Condition and count tests
   logic        cond_bit_w;
   logic [31:0] count_dec_w;
   logic        cond_ok_w;
   logic        count_ok_w;
   logic        taken_w;
   logic        decrement_w;

   // Condition register bit 0 is the most significant bit
   assign cond_bit_w  = cond_reg[CR_TOP - f_w.condition_bit_selector]; // see RL16
   assign count_dec_w = count_register_reg - ONE;
   // b2 clear means decrement first, in both encodings
   assign decrement_w = !b2; // see RL4 // see RL6 // see RL11 // see RL13
   // b0 set ignores the condition; otherwise b1 gives the sense required
   assign cond_ok_w   = b0 || (cond_bit_w == b1); // see RL4 // see RL5 // see RL11 // see RL12
   // b3 picks zero or nonzero of the decremented value
   assign count_ok_w  = b2 || ((count_dec_w == WORD_ZERO) == b3); // see RL4 // see RL6 // see RL11 // see RL13
   // Hint bits y, a, t never enter this term, so they cannot alter the outcome
   assign taken_w     = cond_ok_w && count_ok_w; // see RL7 // see RL17 // see RL9

   // Form checks
   logic z_bad_old_w;
   logic z_bad_new_w;
   logic invalid_w;
   logic wrong_op_w;
   logic apply_w;

   // Old encoding: z in 001zy, 1z00y and 1z1zz
   assign z_bad_old_w = (!b0 && b2 && b3) || (b0 && !b2 && b1) || (b0 && b2 && (b1 || b3 || b4));
   // New encoding: z in 0000z group and 1z1zz
   assign z_bad_new_w = (!b0 && !b2 && b4) || (b0 && b2 && (b1 || b3 || b4));
   // Legacy variant accepts any value in z and y
   assign invalid_w   = !ctrl_reg[CTRL_LEGACY] &&
                        (ctrl_reg[CTRL_NEW_ENC] ? z_bad_new_w : z_bad_old_w); // see RL8 // see RL10
   assign wrong_op_w  = (insn_reg[PRIMARY_HI:PRIMARY_LO] != PRIMARY_OP) || (insn_reg[EXT_HI:EXT_LO] != EXT_OP);
   // A rejected instruction changes neither the count nor the link register
   assign apply_w     = exec_w && !invalid_w && !wrong_op_w;

   // Hint decode
   logic [1:0]   at_w;
   pred_hint_t   pred_w;
   target_hint_t tgt_hint_w;

   // a/t sit at b3,b4 in 001at/011at and at b1,b4 in 1a00t/1a01t
   assign at_w   = !ctrl_reg[CTRL_NEW_ENC] ? ALIGN_ZERO :
                   (!b0 && b2) ? {b3, b4} :
                   (b0 && !b2) ? {b1, b4} : ALIGN_ZERO; // see RL12 // see RL13
   assign pred_w = pred_hint_t'(at_w); // see RL14
   assign tgt_hint_w = target_hint_t'(f_w.branch_hint_field); // see RL15

   // Targets
   logic [31:0] seq_pc_w;
   logic [31:0] target_w;
   branch_status_t status_next;
   logic [31:0] next_pc_next;

   assign seq_pc_w     = cia_reg + INSN_BYTES;
   // Target uses the count value before any decrement
   assign target_w     = {count_register_reg[31:2], ALIGN_ZERO}; // see RL1
   assign next_pc_next = (apply_w && taken_w) ? target_w : seq_pc_w; // see RL18
   assign status_next  = '{done: 1'b1, target_hint: tgt_hint_w, pred_hint: pred_w,
                           y_hint: !ctrl_reg[CTRL_NEW_ENC] && b4,
                           wrong_opcode: wrong_op_w, invalid_form: invalid_w,
                           taken: apply_w && taken_w};

   // Read data captured in the setup cycle so the output comes from a flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata_reg <= WORD_ZERO;
      end else if (setup_w) begin
         prdata_reg <= rd_mux_w;
      end
   end

   // Read mux; GO and unmapped offsets read zero
   assign rd_mux_w = (paddr == OFS_INSN)    ? insn_reg :
                     (paddr == OFS_CIA)     ? cia_reg :
                     (paddr == OFS_COUNT)   ? count_register_reg :
                     (paddr == OFS_LINK)    ? link_reg :
                     (paddr == OFS_COND)    ? cond_reg :
                     (paddr == OFS_FXEXC)   ? fxexc_reg :
                     (paddr == OFS_CTRL)    ? {30'h0000_0000, ctrl_reg} :
                     (paddr == OFS_STATUS)  ? {23'h00_0000, status_reg} :
                     (paddr == OFS_NEXT_PC) ? next_pc_reg : WORD_ZERO;

   // Plain software registers; the branch never writes them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         insn_reg  <= WORD_ZERO;
         cia_reg   <= WORD_ZERO;
         cond_reg  <= WORD_ZERO;
         fxexc_reg <= WORD_ZERO;
         ctrl_reg  <= ALIGN_ZERO;
      end else if (wr_w) begin
         if (paddr == OFS_INSN)  insn_reg  <= pwdata;
         if (paddr == OFS_CIA)   cia_reg   <= pwdata;
         if (paddr == OFS_COND)  cond_reg  <= pwdata; // see RL3
         if (paddr == OFS_FXEXC) fxexc_reg <= pwdata; // see RL3
         if (paddr == OFS_CTRL)  ctrl_reg  <= pwdata[1:0];
      end
   end

   // Count register: software write or decrement on execution
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_register_reg <= WORD_ZERO;
      end else if (wr_w && paddr == OFS_COUNT) begin
         count_register_reg <= pwdata;
      end else if (apply_w && decrement_w) begin
         count_register_reg <= count_dec_w; // see RL4 // see RL6 // see RL11 // see RL13
      end
   end

   // Link register: updated even when not taken
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_reg <= WORD_ZERO;
      end else if (wr_w && paddr == OFS_LINK) begin
         link_reg <= pwdata;
      end else if (apply_w && f_w.link_bit) begin
         link_reg <= seq_pc_w; // see RL2 // see RL18
      end
   end

   // Outcome of each execution
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         status_reg  <= '0;
         next_pc_reg <= WORD_ZERO;
      end else if (exec_w) begin
         status_reg  <= status_next;
         next_pc_reg <= next_pc_next; // see RL1 // see RL18
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence go_s;
      exec_w && !invalid_w && !wrong_op_w;
   endsequence

   sequence go_taken_s;
      go_s ##0 taken_w;
   endsequence

   target_from_count_a: assert property (go_taken_s |=> next_pc_reg == {$past(count_register_reg[31:2]), 2'h0}) // see RL1
      else $error("taken target not count bits with 00");

   link_written_a: assert property (go_s ##0 f_w.link_bit |=> link_reg == $past(cia_reg) + 32'h4) // see RL2
      else $error("link register not loaded with next address");

   link_kept_a: assert property (exec_w && !f_w.link_bit |=> $stable(link_reg)) // see RL2
      else $error("link register changed without link bit");

   fx_cr0_kept_a: assert property (exec_w |=> $stable(fxexc_reg) && $stable(cond_reg[31:28])) // see RL3
      else $error("exception register or field zero changed");

   count_decrement_a: assert property (go_s ##0 !b2 |=> count_register_reg == $past(count_register_reg) - 32'h1) // see RL4
      else $error("count not decremented");

   count_kept_a: assert property (exec_w && b2 |=> $stable(count_register_reg)) // see RL5
      else $error("count changed on non-decrementing code");

   always_taken_a: assert property (go_s ##0 (b0 && b2) |=> status_reg.taken) // see RL7
      else $error("branch-always code not taken");

   z_invalid_a: assert property (exec_w && !ctrl_reg[CTRL_LEGACY] && !ctrl_reg[CTRL_NEW_ENC] && b0 && b2 && b4
                                 |=> status_reg.invalid_form && !status_reg.taken) // see RL8
      else $error("nonzero z bit not flagged");

   legacy_accepts_a: assert property (exec_w && ctrl_reg[CTRL_LEGACY] |=> !status_reg.invalid_form) // see RL10
      else $error("legacy variant flagged invalid form");

   cond_only_a: assert property (go_s ##0 (!b0 && b2 && (cond_bit_w != b1)) |=> !status_reg.taken) // see RL16
      else $error("taken although selected condition failed");

   not_taken_seq_a: assert property (exec_w ##1 !status_reg.taken |-> next_pc_reg == $past(cia_reg) + 32'h4) // see RL18
      else $error("not-taken branch did not go sequential");

   // Outcome per code group, worked out from the count and condition before the edge
   count_test_a: assert property (go_s ##0 (b0 && !b2) |=> // see RL6 // see RL13
      status_reg.taken == ((($past(count_register_reg) - ONE) == WORD_ZERO) == $past(b3)))
      else $error("count-only branch decided wrongly");

   dec_cond_a: assert property (go_s ##0 (!b0 && !b2) |=> // see RL4 // see RL11
      status_reg.taken == (((($past(count_register_reg) - ONE) == WORD_ZERO) == $past(b3)) &&
                           ($past(cond_bit_w) == $past(b1))))
      else $error("decrement-and-condition branch decided wrongly");

   cond_test_a: assert property (go_s ##0 (!b0 && b2) |=> // see RL5 // see RL12
      status_reg.taken == ($past(cond_bit_w) == $past(b1)))
      else $error("condition-only branch decided wrongly");

   // Hints are reported but never steer the outcome
   pred_hint_a: assert property (exec_w && ctrl_reg[CTRL_NEW_ENC] && !b0 && b2 |=> // see RL12 // see RL14
      status_reg.pred_hint == pred_hint_t'($past(f_w.branch_option_field[1:0])))
      else $error("prediction hint not taken from a and t");

   old_hints_a: assert property (exec_w && !ctrl_reg[CTRL_NEW_ENC] |=> // see RL9 // see RL14
      status_reg.pred_hint == PRED_NONE && status_reg.y_hint == $past(b4))
      else $error("old encoding hints reported wrongly");

   target_hint_a: assert property (exec_w |=> // see RL15
      status_reg.target_hint == target_hint_t'($past(f_w.branch_hint_field)))
      else $error("branch hint field not reported");

   // Rejected forms under the newer encoding, and what a rejection leaves alone
   z_invalid_new_a: assert property (exec_w && !ctrl_reg[CTRL_LEGACY] && ctrl_reg[CTRL_NEW_ENC] // see RL8
      && !b0 && !b2 && b4 |=> status_reg.invalid_form && !status_reg.taken)
      else $error("nonzero z bit not flagged in new encoding");

   rejected_kept_a: assert property (exec_w && (invalid_w || wrong_op_w) |=> // see RL8
      $stable(count_register_reg) && $stable(link_reg))
      else $error("rejected instruction changed count or link");

endmodule

`default_nettype wire

//--- apb_host.sv
// Purpose: APB master standing in for the core's register access side
// Assumes: One transfer at a time, signals changed only just after a rising edge
// Notes:   Waits on pready without a bound; the bench watchdog cuts a hang short

`default_nettype none

module apb_host (
   // Clock
   input  wire logic        clk,
   // APB master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // Setup then access; request held until pready is seen high at an edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for the branch-to-count-register unit
// Assumes: Register map and status layout of the branch_count_pkg offsets
// Notes:   Every option code is run under both encodings, strict and legacy

`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import branch_count_pkg::*;

   localparam logic [31:0] CIA   = 32'h0001_2340;
   localparam logic [31:0] LINK0 = 32'h5555_AAAA;
   localparam logic [31:0] FX0   = 32'h3C3C_0000;

   logic        clk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] r;
   logic        e;
   int          bad_count;
   int          check_count;

   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   branch_cond_to_count_reg u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   apb_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic        y;
      u_host.xfer(1'b1, a, d, x, y);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic err);
      u_host.xfer(1'b0, a, 32'h0000_0000, d, err);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One execution with the reference outcome worked out beside it
   task automatic run_case(input logic [4:0] opt, input logic [4:0] sel, input logic cbit,
                           input logic [31:0] cnt, input logic enc, input logic leg,
                           input logic lnk, input logic [1:0] hint);
      logic [31:0] cond;
      logic [31:0] st;
      logic [31:0] mask;
      logic [31:0] exp_st;
      logic [1:0]  pred;
      logic        inv;
      logic        tk;
      cond = 32'hA5C3_0F96;
      cond[31-sel] = cbit;
      wr(OFS_CTRL, {30'h0, leg, enc});
      wr(OFS_INSN, {PRIMARY_OP, opt, sel, 3'h0, hint, EXT_OP, lnk});
      wr(OFS_CIA, CIA);
      wr(OFS_COUNT, cnt);
      wr(OFS_LINK, LINK0);
      wr(OFS_COND, cond);
      wr(OFS_FXEXC, FX0);
      wr(OFS_GO, ONE);
      // Nonzero must-be-zero bits only matter outside the legacy variant
      inv = !leg & ((opt[4] & opt[2] & (opt[3] | opt[1] | opt[0])) |
            (enc ? (!opt[4] & !opt[2] & opt[0]) : ((!opt[4] & opt[2] & opt[1]) | (opt[4] & !opt[2] & opt[3]))));
      tk = !inv & (opt[2] | (((cnt - ONE) != WORD_ZERO) ^ opt[1])) & (opt[4] | (cbit == opt[3]));
      pred = !enc ? 2'h0 : (!opt[4] & opt[2]) ? {opt[1], opt[0]} : (opt[4] & !opt[2]) ? {opt[3], opt[0]} : 2'h0;
      mask = inv ? 32'h0000_0107 : (enc ? 32'h0000_01F7 : 32'h0000_01FF);
      exp_st = {23'h0, 1'b1, hint, pred, !enc & opt[0], 1'b0, inv, tk};
      rd(OFS_STATUS, st, e);
      check("status", st & mask, exp_st & mask);
      rd(OFS_NEXT_PC, st, e);
      check("next_pc", st, tk ? {cnt[31:2], ALIGN_ZERO} : CIA + INSN_BYTES);
      rd(OFS_COUNT, st, e);
      check("count", st, (!inv & !opt[2]) ? cnt - ONE : cnt);
      rd(OFS_LINK, st, e);
      check("link", st, (!inv & lnk) ? CIA + INSN_BYTES : LINK0);
      rd(OFS_FXEXC, st, e);
      check("fxexc", st, FX0);
      rd(OFS_COND, st, e);
      check("cond", st, cond);
   endtask

   // Watchdog sized well beyond the expected run of about 21600 cycles
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      results();
   end

   // Main sequence
   initial begin
      resetn = 1'b0;
      bad_count = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd(OFS_STATUS, r, e);
      check("reset status", r, WORD_ZERO);
      rd(OFS_COUNT, r, e);
      check("reset count", r, WORD_ZERO);
      check("mapped read error", {31'h0, e}, WORD_ZERO);
      $display("test reset values done");
      for (int m = 0; m < 4; m++) begin
         for (int b = 0; b < 32; b++)
            for (int k = 0; k < 4; k++)
               run_case(5'(b), 5'(b * 3 + k * 5), k[0], k[1] ? ONE : 32'hFFFF_FFF3,
                        m[0], m[1], b[0] ^ k[0], 2'(k));
         $display("test decode encoding %0d legacy %0d done", m[0], m[1]);
      end
      // Foreign opcode must not branch or link
      wr(OFS_CTRL, WORD_ZERO);
      wr(OFS_INSN, {PRIMARY_OP ^ 6'h01, 5'h14, 5'h00, 3'h0, 2'h0, EXT_OP, 1'b1});
      wr(OFS_COUNT, 32'h0000_8000);
      wr(OFS_LINK, LINK0);
      wr(OFS_GO, ONE);
      rd(OFS_STATUS, r, e);
      check("opcode status", r & 32'h0000_0105, 32'h0000_0104);
      rd(OFS_NEXT_PC, r, e);
      check("opcode next_pc", r, CIA + INSN_BYTES);
      rd(OFS_LINK, r, e);
      check("opcode link", r, LINK0);
      $display("test foreign opcode done");
      // Unmapped, write-only and read-only places
      u_host.xfer(1'b1, 8'h40, 32'hFFFF_FFFF, r, e);
      check("unmapped write error", {31'h0, e}, ONE);
      rd(8'h40, r, e);
      check("unmapped read error", {31'h0, e}, ONE);
      check("unmapped read data", r, WORD_ZERO);
      rd(OFS_GO, r, e);
      check("go read", r, WORD_ZERO);
      wr(OFS_STATUS, 32'hFFFF_FFFF);
      rd(OFS_STATUS, r, e);
      check("status after write", r & 32'h0000_0105, 32'h0000_0104);
      $display("test register access done");
      results();
   end
endmodule

`default_nettype wire
